/* File: src/scpi_parser_pkg.sv */
/*
 * Constants, character codes, parser states and the built-in command word
 * table for the program message parser.
 * Assumes the executor downstream knows the word table indices below.
 */
package scpi_parser_pkg;

	// character codes
	localparam logic [7:0] CH_LF    = 8'h0a;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_STAR  = 8'h2a;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_COLON = 8'h3a;
	localparam logic [7:0] CH_SEMI  = 8'h3b;
	localparam logic [7:0] CH_QUERY = 8'h3f;
	localparam logic [7:0] CH_DIG0  = 8'h30;
	localparam logic [7:0] CH_DIG9  = 8'h39;
	localparam logic [7:0] CH_UA    = 8'h41;
	localparam logic [7:0] CH_UZ    = 8'h5a;
	localparam logic [7:0] CH_LA    = 8'h61;
	localparam logic [7:0] CH_LZ    = 8'h7a;
	localparam logic [7:0] CASE_BIT = 8'h20;

	// word geometry
	localparam int         MAX_LEN     = 12;
	localparam logic [3:0] MAX_LEN_4   = 4'hc;
	localparam logic [3:0] PLAIN_LEN   = 4'h4;  // longest word with no short form
	localparam logic [3:0] VOWEL_SHORT = 4'h3;
	localparam logic [3:0] CONS_SHORT  = 4'h4;
	localparam logic [3:0] EXC_SHORT   = 4'h2;
	localparam logic [1:0] COMMON_LEN  = 2'h3;

	// output queue
	localparam int Q_WIDTH = 9;   // eoi flag above the byte
	localparam int Q_DEPTH = 32;
	localparam int Q_LVL_W = 6;
	localparam logic [Q_LVL_W-1:0] Q_FILL_MAX = 6'h1e;

	// node index meaning "root" / "no implied child"
	localparam logic [3:0] NODE_NONE  = 4'hf;
	localparam int         WORD_COUNT = 10;

	// command word table: long spelling, length, parent, suffix, flags
	localparam logic [95:0] WORD_TXT [WORD_COUNT] = '{
		"STATUS", "OPERATION", "ENABLE", "PRESET", "SENSE",
		{"T", "COUPLE"}, "FUNCTION", "INITIATE", "IMMEDIATE", "CALC"};
	localparam logic [3:0] WORD_LEN [WORD_COUNT] = '{
		4'h6, 4'h9, 4'h6, 4'h6, 4'h5, 4'h7, 4'h8, 4'h8, 4'h9, 4'h4};
	localparam logic [3:0] WORD_PAR [WORD_COUNT] = '{
		4'hf, 4'h0, 4'h1, 4'h0, 4'hf, 4'h4, 4'h4, 4'hf, 4'h7, 4'hf};
	localparam logic [3:0] WORD_SFX [WORD_COUNT] = '{
		4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1};
	localparam logic [3:0] WORD_IMPL [WORD_COUNT] = '{
		4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h8, 4'hf, 4'hf};
	// optional root words; a child of one may stand as the root
	localparam logic [WORD_COUNT-1:0] WORD_OPT = 10'h010;
	// thermocouple_word: short form is its first two letters
	localparam logic [WORD_COUNT-1:0] WORD_EXC = 10'h020;

	typedef enum logic [2:0] {
		ST_START, ST_WORD, ST_PATH, ST_STAR, ST_PARAM, ST_DROP
	} parse_state_e;

endpackage

/* File: src/byte_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides and a fill level.
 * Assumes a single clock; reads and writes may occur in the same cycle.
 */
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic                       clk_i,
	input  wire logic                       reset_n_i,
	input  wire logic                       in_valid_i,
	output logic                            in_ready_o,
	input  wire logic [WIDTH-1:0]           in_data_i,
	output logic                            out_valid_o,
	input  wire logic                       out_ready_i,
	output logic [WIDTH-1:0]                out_data_o,
	output logic [$clog2(DEPTH):0]          level_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;

	// full when pointers differ only in the wrap bit
	assign level_o     = wr_ptr - rd_ptr;
	assign in_ready_o  = (level_o != (AW+1)'(DEPTH));
	assign out_valid_o = (level_o != '0);
	assign out_data_o  = mem[rd_ptr[AW-1:0]];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// storage write
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end

	// pointer update
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

endmodule

/* File: src/scpi_message_parser.sv */
/*
 * Program message parser: splits the incoming byte stream into command
 * words, resolves them against the word table along a path pointer, hands
 * commands to an executor and queues query replies for the talker.
 * Assumes rx/resp/tx handshakes come from logic on clk_i; talk_i is a pin.
 */
// Overview of operation
// - words of four letters or fewer match only when fully spelled.
// - longer word with vowel fourth letter abbreviates to first three letters.
// - longer word with consonant fourth letter abbreviates to first four.
// - the thermocouple_word abbreviates to its first two letters.
// - short forms keep the query mark and mandatory numeric suffix.
// - optional bracketed words are implied; sent or omitted, same result, except a query leaves an implied child out (init? is not init:imm?).
// - an asterisk plus three letters is a common command.
// - each colon inside a path moves the pointer one level down.
// - a colon right after a semicolon returns the pointer to root.
// - after a bare semicolon the next word resolves at the same level, but under init after init ran its implied child.
// - the pointer never moves up; only a restart from root.
// - a leading colon on a message is optional.
// - each message starts at root; optional root children count as root.
// - common commands run anywhere and leave the pointer alone.
// - commands execute strictly in message order.
// - an invalid command raises an error and is not executed.
// - after an error the rest of the message is discarded.
// - replies wait in the output queue until addressed to talk.
// - replies separated by semicolons, items within a reply by commas.
// - every reply message ends with line feed carrying eoi.
// - word matching ignores letter case.
// - partial truncations are rejected with an error.
module scpi_message_parser (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        rx_valid_i,
	output logic             rx_ready_o,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_eoi_i,
	output logic             cmd_valid_o,
	output logic [3:0]       cmd_id_o,
	output logic             cmd_query_o,
	output logic             common_valid_o,
	output logic [23:0]      common_code_o,
	output logic             common_query_o,
	output logic             err_o,
	input  wire logic        resp_valid_i,
	output logic             resp_ready_o,
	input  wire logic [7:0]  resp_data_i,
	input  wire logic        resp_item_end_i,
	input  wire logic        resp_end_i,
	input  wire logic        talk_i,
	output logic             tx_valid_o,
	input  wire logic        tx_ready_i,
	output logic [7:0]       tx_data_o,
	output logic             tx_eoi_o
);
	scpi_parser_pkg::parse_state_e state;
	scpi_parser_pkg::parse_state_e next_state;

	logic [95:0] word;
	logic [3:0]  wlen;
	logic [3:0]  wsfx;
	logic        wqry;
	logic [95:0] next_word;
	logic [3:0]  next_wlen;
	logic [3:0]  next_wsfx;
	logic        next_wqry;
	logic [23:0] scode;
	logic [1:0]  scnt;
	logic        squery;
	logic [23:0] next_scode;
	logic [1:0]  next_scnt;
	logic        next_squery;
	logic [3:0]  cur_parent;
	logic [3:0]  hit_idx;
	logic        hit_found;
	logic [3:0]  exec_id;
	logic        acc;
	logic        bad_char;
	logic        word_done;
	logic        go_down;
	logic        go_root;
	logic        do_err;
	logic        do_end;
	logic        do_exec;
	logic        do_common;
	logic [7:0]  uc;
	logic [3:0]  q_issued;
	logic [3:0]  q_done;
	logic        msg_closed;
	logic        comma_due;
	logic        semi_due;
	logic        resp_acc;
	logic        q_new;
	logic        q_wr;
	logic [8:0]  q_wdata;
	logic        q_in_ready;
	logic        q_out_valid;
	logic        q_out_ready;
	logic [8:0]  q_out_data;
	logic [5:0]  q_level;
	logic        talk_meta;
	logic        talk_sync;

	function automatic logic is_letter(input logic [7:0] c);
		return (c >= scpi_parser_pkg::CH_UA && c <= scpi_parser_pkg::CH_UZ) ||
			(c >= scpi_parser_pkg::CH_LA && c <= scpi_parser_pkg::CH_LZ);
	endfunction

	function automatic logic is_digit(input logic [7:0] c);
		return c >= scpi_parser_pkg::CH_DIG0 && c <= scpi_parser_pkg::CH_DIG9;
	endfunction

	// short form length of a table entry
	function automatic logic [3:0] short_len(input int i);
		logic [3:0] l;
		logic [7:0] c4;
		l = scpi_parser_pkg::WORD_LEN[i];
		c4 = scpi_parser_pkg::WORD_TXT[i][8*(int'(l)-4) +: 8];
		if (scpi_parser_pkg::WORD_EXC[i]) begin
			return scpi_parser_pkg::EXC_SHORT;
		end else if (l <= scpi_parser_pkg::PLAIN_LEN) begin
			return l;
		end else if (c4 == "A" || c4 == "E" || c4 == "I" || c4 == "O" ||
				c4 == "U") begin
			return scpi_parser_pkg::VOWEL_SHORT;
		end
		return scpi_parser_pkg::CONS_SHORT;
	endfunction

	// typed word (left aligned, upper case) against table entry i
	function automatic logic word_hit(input int i, input logic [95:0] w,
			input logic [3:0] wl, input logic [3:0] ws);
		logic [3:0] l;
		logic       same;
		l = scpi_parser_pkg::WORD_LEN[i];
		same = 1'b1;
		for (int k = 0; k < scpi_parser_pkg::MAX_LEN; k++) begin
			if (k < int'(wl) && k < int'(l)) begin
				if (w[8*(scpi_parser_pkg::MAX_LEN-1-k) +: 8] !=
						scpi_parser_pkg::WORD_TXT[i][8*(int'(l)-1-k) +: 8]) begin
					same = 1'b0;
				end
			end
		end
		// only the full or the exact short length is legal
		return same && (wl == l || wl == short_len(i)) &&
			(ws == scpi_parser_pkg::WORD_SFX[i]);
	endfunction

	assign acc      = rx_valid_i && rx_ready_o;
	assign uc       = is_letter(rx_data_i) ?
		(rx_data_i & ~scpi_parser_pkg::CASE_BIT) : rx_data_i;
	assign exec_id  = (scpi_parser_pkg::WORD_IMPL[hit_idx] !=
		scpi_parser_pkg::NODE_NONE && !next_wqry) ?
		scpi_parser_pkg::WORD_IMPL[hit_idx] : hit_idx;

	// word and common-code view including the current byte
	always_comb begin
		next_word   = (state == scpi_parser_pkg::ST_WORD) ? word : '0;
		next_wlen   = (state == scpi_parser_pkg::ST_WORD) ? wlen : '0;
		next_wsfx   = (state == scpi_parser_pkg::ST_WORD) ? wsfx : '0;
		next_wqry   = (state == scpi_parser_pkg::ST_WORD) ? wqry : 1'b0;
		next_scode  = scode;
		next_scnt   = scnt;
		next_squery = squery;
		bad_char    = 1'b0;
		if (state == scpi_parser_pkg::ST_STAR) begin
			if (is_letter(rx_data_i) && scnt != scpi_parser_pkg::COMMON_LEN) begin
				next_scode = {scode[15:0], uc};
				next_scnt  = scnt + 2'h1;
			end else if (rx_data_i == scpi_parser_pkg::CH_QUERY &&
					scnt == scpi_parser_pkg::COMMON_LEN && !squery) begin
				next_squery = 1'b1;
			end
		end else if (is_letter(rx_data_i)) begin
			if (next_wqry || next_wsfx != '0 ||
					next_wlen == scpi_parser_pkg::MAX_LEN_4) begin
				bad_char = 1'b1;
			end else begin
				next_word[8*(scpi_parser_pkg::MAX_LEN-1-int'(next_wlen)) +: 8] = uc;
				next_wlen = next_wlen + 4'h1;
			end
		end else if (is_digit(rx_data_i)) begin
			if (next_wlen == '0 || next_wqry || next_wsfx != '0) begin
				bad_char = 1'b1;
			end
			next_wsfx = 4'(rx_data_i - scpi_parser_pkg::CH_DIG0);
		end else if (rx_data_i == scpi_parser_pkg::CH_QUERY) begin
			bad_char  = next_wqry || next_wlen == '0;
			next_wqry = 1'b1;
		end
	end

	// resolve the word under the path pointer, or under an optional root
	always_comb begin
		hit_idx   = scpi_parser_pkg::NODE_NONE;
		hit_found = 1'b0;
		for (int i = 0; i < scpi_parser_pkg::WORD_COUNT; i++) begin
			if (!hit_found && word_hit(i, next_word, next_wlen, next_wsfx) &&
					(scpi_parser_pkg::WORD_PAR[i] == cur_parent ||
					(cur_parent == scpi_parser_pkg::NODE_NONE &&
					scpi_parser_pkg::WORD_PAR[i] != scpi_parser_pkg::NODE_NONE &&
					scpi_parser_pkg::WORD_OPT[scpi_parser_pkg::WORD_PAR[i]]))) begin
				hit_idx   = 4'(i);
				hit_found = 1'b1;
			end
		end
	end

	// byte classification and next parser state
	always_comb begin
		next_state = state;
		word_done  = 1'b0;
		go_down    = 1'b0;
		go_root    = 1'b0;
		do_err     = 1'b0;
		do_common  = 1'b0;
		do_end     = acc && (rx_data_i == scpi_parser_pkg::CH_LF || rx_eoi_i);
		if (acc) begin
			unique case (state)
				scpi_parser_pkg::ST_START: begin
					if (rx_data_i == scpi_parser_pkg::CH_COLON) begin
						go_root    = 1'b1;
						next_state = scpi_parser_pkg::ST_PATH;
					end else if (rx_data_i == scpi_parser_pkg::CH_STAR) begin
						next_state = scpi_parser_pkg::ST_STAR;
					end else if (is_letter(rx_data_i)) begin
						next_state = scpi_parser_pkg::ST_WORD;
					end else if (rx_data_i != scpi_parser_pkg::CH_SPACE &&
							rx_data_i != scpi_parser_pkg::CH_LF) begin
						do_err = 1'b1;
					end
				end
				scpi_parser_pkg::ST_WORD: begin
					if (rx_data_i == scpi_parser_pkg::CH_COLON) begin
						go_down    = 1'b1;
						do_err     = wqry;
						next_state = scpi_parser_pkg::ST_PATH;
					end else if (rx_data_i == scpi_parser_pkg::CH_SEMI) begin
						word_done  = 1'b1;
						next_state = scpi_parser_pkg::ST_START;
					end else if (rx_data_i == scpi_parser_pkg::CH_SPACE) begin
						word_done  = 1'b1;
						next_state = scpi_parser_pkg::ST_PARAM;
					end else if (rx_data_i == scpi_parser_pkg::CH_LF) begin
						word_done  = 1'b1;
					end else begin
						do_err = bad_char || !(is_letter(rx_data_i) ||
							is_digit(rx_data_i) ||
							rx_data_i == scpi_parser_pkg::CH_QUERY);
					end
				end
				scpi_parser_pkg::ST_PATH: begin
					if (is_letter(rx_data_i)) begin
						next_state = scpi_parser_pkg::ST_WORD;
					end else begin
						do_err = 1'b1;
					end
				end
				scpi_parser_pkg::ST_STAR: begin
					if (scnt == scpi_parser_pkg::COMMON_LEN &&
							(rx_data_i == scpi_parser_pkg::CH_SEMI ||
							rx_data_i == scpi_parser_pkg::CH_SPACE ||
							rx_data_i == scpi_parser_pkg::CH_LF)) begin
						do_common  = 1'b1;
						next_state = (rx_data_i == scpi_parser_pkg::CH_SPACE) ?
							scpi_parser_pkg::ST_PARAM : scpi_parser_pkg::ST_START;
					end else if (next_scnt == scnt && next_squery == squery) begin
						do_err = 1'b1;
					end
				end
				scpi_parser_pkg::ST_PARAM: begin
					if (rx_data_i == scpi_parser_pkg::CH_SEMI) begin
						next_state = scpi_parser_pkg::ST_START;
					end
				end
				scpi_parser_pkg::ST_DROP: begin
					next_state = scpi_parser_pkg::ST_DROP;
				end
			endcase
			// eoi on a data byte closes whatever was being built
			if (rx_eoi_i && rx_data_i != scpi_parser_pkg::CH_LF && !do_err) begin
				if (next_state == scpi_parser_pkg::ST_WORD) begin
					word_done = 1'b1;
				end else if (next_state == scpi_parser_pkg::ST_STAR) begin
					do_common = next_scnt == scpi_parser_pkg::COMMON_LEN;
					do_err    = !do_common;
				end else if (next_state == scpi_parser_pkg::ST_PATH) begin
					do_err = !go_root;
				end
			end
			if ((word_done || go_down) && !hit_found) begin
				do_err = 1'b1;
			end
			if (do_err) begin
				next_state = scpi_parser_pkg::ST_DROP;
			end
			if (do_end) begin
				next_state = scpi_parser_pkg::ST_START;
			end
		end
	end
	assign do_exec = word_done && !do_err;

	// parser state and word buffers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state  <= scpi_parser_pkg::ST_START;
			word   <= '0;
			wlen   <= '0;
			wsfx   <= '0;
			wqry   <= 1'b0;
			scode  <= '0;
			scnt   <= '0;
			squery <= 1'b0;
		end else if (acc) begin
			state  <= next_state;
			word   <= next_word;
			wlen   <= next_wlen;
			wsfx   <= next_wsfx;
			wqry   <= next_wqry;
			scode  <= (state == scpi_parser_pkg::ST_STAR) ? next_scode : '0;
			scnt   <= (state == scpi_parser_pkg::ST_STAR) ? next_scnt : '0;
			squery <= (state == scpi_parser_pkg::ST_STAR) && next_squery;
		end
	end

	// path pointer: only down, or back to root
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cur_parent <= scpi_parser_pkg::NODE_NONE;
		end else if (do_end) begin
			cur_parent <= scpi_parser_pkg::NODE_NONE;
		end else if (go_root) begin
			cur_parent <= scpi_parser_pkg::NODE_NONE;
		end else if (go_down && !do_err) begin
			cur_parent <= hit_idx;
		end else if (do_exec) begin
			cur_parent <= scpi_parser_pkg::WORD_PAR[exec_id];
		end
	end

	// command and error strobes, in byte order
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_ready_o     <= 1'b0;
			cmd_valid_o    <= 1'b0;
			cmd_id_o       <= '0;
			cmd_query_o    <= 1'b0;
			common_valid_o <= 1'b0;
			common_code_o  <= '0;
			common_query_o <= 1'b0;
			err_o          <= 1'b0;
		end else begin
			rx_ready_o     <= 1'b1;
			cmd_valid_o    <= do_exec;
			cmd_id_o       <= do_exec ? exec_id : cmd_id_o;
			cmd_query_o    <= do_exec ? next_wqry : cmd_query_o;
			common_valid_o <= do_common && !do_err;
			common_code_o  <= do_common ? next_scode : common_code_o;
			common_query_o <= do_common ? next_squery : common_query_o;
			err_o          <= do_err;
		end
	end

	assign resp_acc = resp_valid_i && resp_ready_o;
	// one more reply is owed for a query executed this cycle
	assign q_new    = (do_exec && next_wqry) ||
		(do_common && !do_err && next_squery);

	// reply assembly: separators, then bytes, then terminator
	always_comb begin
		q_wr    = 1'b0;
		q_wdata = {1'b0, resp_data_i};
		if (comma_due) begin
			q_wr    = 1'b1;
			q_wdata = {1'b0, scpi_parser_pkg::CH_COMMA};
		end else if (semi_due && resp_valid_i) begin
			q_wr    = 1'b1;
			q_wdata = {1'b0, scpi_parser_pkg::CH_SEMI};
		end else if (resp_acc) begin
			q_wr    = 1'b1;
		end else if (msg_closed && q_done == q_issued) begin
			q_wr    = 1'b1;
			q_wdata = {1'b1, scpi_parser_pkg::CH_LF};
		end
	end

	// reply bookkeeping for the message in progress
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q_issued     <= '0;
			q_done       <= '0;
			msg_closed   <= 1'b0;
			comma_due    <= 1'b0;
			semi_due     <= 1'b0;
			resp_ready_o <= 1'b0;
		end else begin
			comma_due <= resp_acc && resp_item_end_i && !resp_end_i;
			if (q_wr && q_wdata[8]) begin
				q_issued   <= 4'(q_new); // a new query wins over the clear
				q_done     <= '0;
				msg_closed <= do_end && q_new;
				semi_due   <= 1'b0;
			end else begin
				q_issued <= q_issued + 4'(q_new);
				q_done   <= q_done + 4'(resp_acc && resp_end_i);
				if (do_end && (q_issued != '0 || q_new)) begin
					msg_closed <= 1'b1;
				end
				if (resp_acc && resp_end_i) begin
					semi_due <= 1'b1;
				end else if (q_wr && !comma_due && semi_due) begin
					semi_due <= 1'b0;
				end
			end
			resp_ready_o <= !(resp_acc && resp_item_end_i && !resp_end_i) &&
				!(resp_acc && resp_end_i) &&
				!(semi_due && !(resp_valid_i && !comma_due)) &&
				(q_level <= scpi_parser_pkg::Q_FILL_MAX);
		end
	end

	byte_fifo #(
		.WIDTH(scpi_parser_pkg::Q_WIDTH),
		.DEPTH(scpi_parser_pkg::Q_DEPTH)
	) out_queue (
		.clk_i      (clk_i),
		.reset_n_i  (reset_n_i),
		.in_valid_i (q_wr),
		.in_ready_o (q_in_ready),
		.in_data_i  (q_wdata),
		.out_valid_o(q_out_valid),
		.out_ready_i(q_out_ready),
		.out_data_o (q_out_data),
		.level_o    (q_level)
	);

	// talk address pin synchroniser
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			talk_meta <= 1'b0;
			talk_sync <= 1'b0;
		end else begin
			talk_meta <= talk_i;
			talk_sync <= talk_meta;
		end
	end

	// talker: drains the queue only while addressed to talk
	assign q_out_ready = talk_sync && (!tx_valid_o || tx_ready_i);
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_valid_o <= 1'b0;
			tx_data_o  <= '0;
			tx_eoi_o   <= 1'b0;
		end else if (q_out_ready && q_out_valid) begin
			tx_valid_o <= 1'b1;
			tx_data_o  <= q_out_data[7:0];
			tx_eoi_o   <= q_out_data[8];
		end else if (tx_ready_i) begin
			tx_valid_o <= 1'b0;
		end
	end

	default clocking dc @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_item_split;
		resp_acc && resp_item_end_i && !resp_end_i;
	endsequence
	sequence s_comma_written;
		q_wr && q_wdata == {1'b0, scpi_parser_pkg::CH_COMMA};
	endsequence
	sequence s_semi_colon;
		acc && rx_data_i == scpi_parser_pkg::CH_SEMI && !do_err &&
			state != scpi_parser_pkg::ST_DROP
			##1 acc && rx_data_i == scpi_parser_pkg::CH_COLON;
	endsequence

	AST_ERR_NO_EXEC: assert property (err_o |-> !cmd_valid_o)
		else $error("command executed together with error");
	AST_DROP_REST: assert property (
		state == scpi_parser_pkg::ST_DROP |=> !cmd_valid_o && !common_valid_o)
		else $error("command executed after error");
	AST_COMMON_PATH: assert property (
		common_valid_o && !$past(do_end) |-> cur_parent == $past(cur_parent))
		else $error("common command moved path pointer");
	AST_MSG_ROOT: assert property (
		do_end |=> cur_parent == scpi_parser_pkg::NODE_NONE)
		else $error("pointer not at root after message end");
	AST_SEMI_COLON_ROOT: assert property (
		s_semi_colon |=> cur_parent == scpi_parser_pkg::NODE_NONE)
		else $error("colon after semicolon did not reset pointer");
	AST_DOWN: assert property (
		go_down && !do_err && !do_end |=> cur_parent == $past(hit_idx))
		else $error("colon did not move pointer down");
	AST_COMMA: assert property (s_item_split |=> s_comma_written)
		else $error("item separator missing");
	AST_TALK_ONLY: assert property (
		$rose(tx_valid_o) |-> $past(talk_sync))
		else $error("reply sent while not addressed to talk");
	AST_EOI_LF: assert property (
		tx_valid_o && tx_eoi_o |-> tx_data_o == scpi_parser_pkg::CH_LF)
		else $error("eoi without line feed");
	AST_NO_OVERFLOW: assert property (resp_acc |-> q_in_ready)
		else $error("reply byte taken with queue full");

endmodule

/* File: tb/host_model.sv */
/*
 * Host computer model: sends program messages byte by byte and reads
 * the reply once it addresses the device to talk.
 * Assumes the bench adds timeouts to its mismatch count at the end.
 */
module host_model (
	input  wire logic       clk_i,
	input  wire logic       rx_ready_i,
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	output logic            rx_eoi_o,
	output logic            talk_o,
	input  wire logic       tx_valid_i,
	output logic            tx_ready_o,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_eoi_i
);
	timeunit 1ns;
	timeprecision 1ns;
	int timeouts = 0;
	int seed = 25;
	// idle bus at time zero
	initial begin
		{rx_valid_o, rx_eoi_o, talk_o, tx_ready_o} = 4'h0;
		rx_data_o = 8'h00;
	end
	// one byte a cycle, held until taken; last byte carries eoi
	task automatic send(input string m);
		int n;
		for (int i = 0; i < m.len(); i++) begin
			@(negedge clk_i);
			rx_valid_o = 1'b1;
			rx_data_o = m[i];
			rx_eoi_o = (i == m.len() - 1);
			@(posedge clk_i);
			for (n = 0; n < 20 && rx_ready_i !== 1'b1; n++) @(posedge clk_i);
			if (n == 20) timeouts++;
		end
		@(negedge clk_i);
		{rx_valid_o, rx_eoi_o} = 2'h0;
		rx_data_o = ~rx_data_o; // released line shows no stale byte
	endtask
	// talk, stall at random, take bytes up to the one with eoi
	task automatic read(output string s);
		int n;
		s = "";
		@(negedge clk_i);
		talk_o = 1'b1;
		for (n = 0; n < 200; n++) begin
			@(negedge clk_i);
			tx_ready_o = 1'($random(seed));
			@(posedge clk_i);
			if (tx_valid_i === 1'b1 && tx_ready_o) begin
				s = {s, string'(tx_data_i)};
				if (tx_eoi_i === 1'b1) break;
			end
		end
		if (n == 200) timeouts++;
		@(negedge clk_i);
		{talk_o, tx_ready_o} = 2'h0;
	endtask
endmodule

/* File: tb/scpi_message_parser_test.sv */
/*
 * Self-checking bench for the program message parser: host model on the
 * bus, bench as executor, command events compared with expected queues.
 * Assumes one 20 MHz clock and an async active-low reset.
 */
module scpi_message_parser_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 0, reset_n_i = 0, rx_valid_i, rx_ready_o, rx_eoi_i;
	logic        cmd_valid_o, cmd_query_o, common_valid_o, common_query_o;
	logic        err_o, resp_valid_i = 0, resp_ready_o, talk_i, tx_eoi_o;
	logic        resp_item_end_i = 0, resp_end_i = 0, tx_valid_o, tx_ready_i;
	logic [7:0]  rx_data_i, resp_data_i = 8'h00, tx_data_o;
	logic [3:0]  cmd_id_o;
	logic [23:0] common_code_o;
	logic [31:0] got[$];
	int          mismatches = 0, checks_done = 0;
	string       reply;
	always #25 clk_i = ~clk_i;
	scpi_message_parser dut (.clk_i, .reset_n_i, .rx_valid_i, .rx_ready_o,
		.rx_data_i, .rx_eoi_i, .cmd_valid_o, .cmd_id_o, .cmd_query_o,
		.common_valid_o, .common_code_o, .common_query_o, .err_o,
		.resp_valid_i, .resp_ready_o, .resp_data_i, .resp_item_end_i,
		.resp_end_i, .talk_i, .tx_valid_o, .tx_ready_i, .tx_data_o, .tx_eoi_o);
	host_model host (.clk_i, .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i), .rx_eoi_o(rx_eoi_i), .talk_o(talk_i),
		.tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
		.tx_data_i(tx_data_o), .tx_eoi_i(tx_eoi_o));
	// record command, common and error pulses as coded words
	always @(posedge clk_i) begin
		if (cmd_valid_o === 1'b1) got.push_back({27'h0, cmd_id_o, cmd_query_o});
		if (common_valid_o === 1'b1)
			got.push_back({7'h1, common_query_o, common_code_o});
		if (err_o === 1'b1) got.push_back(32'hffffffff);
	end
	task automatic final_report;
		mismatches += host.timeouts;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] g, e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %0t event %h want %h", $time, g, e);
		end
	endtask
	task automatic check_str(input string g, e);
		checks_done++;
		if (g != e) begin
			mismatches++;
			$display("CHECK FAILED %0t reply %s", $time, g);
		end
	endtask
	// one message, then its events in order
	task automatic run(input string m, input logic [31:0] e[$]);
		got = {};
		host.send(m);
		repeat (3) @(posedge clk_i);
		check(got.size(), e.size());
		foreach (e[i]) check(got[i], e[i]);
	endtask
	// executor reply byte, held until the parser takes it
	task automatic give(input logic [7:0] d, input logic it, en);
		int n;
		@(negedge clk_i);
		{resp_valid_i, resp_item_end_i, resp_end_i} = {1'b1, it, en};
		resp_data_i = d;
		@(posedge clk_i);
		for (n = 0; n < 20 && resp_ready_o !== 1'b1; n++) @(posedge clk_i);
		if (n == 20) begin
			mismatches++;
			final_report();
		end
		@(negedge clk_i);
		resp_valid_i = 1'b0;
		resp_data_i = ~d;
	endtask
	// executor answers a lone one-item query, host reads the whole reply
	task automatic answer(input logic [7:0] d);
		give(d, 1'b0, 1'b1);
		host.read(reply);
		check_str(reply, {string'(d), "\n"});
	endtask
	// main sequence
	initial begin
		repeat (3) @(negedge clk_i);
		reset_n_i = 1'b1;
		repeat (2) @(posedge clk_i);
		run("stat:oper:enab?;enab?\n", '{32'h5, 32'h5});
		give(8'h30, 1'b1, 1'b0);
		give(8'h35, 1'b0, 1'b1);
		give(8'h31, 1'b0, 1'b1);
		repeat (6) @(posedge clk_i);
		check(tx_valid_o, 1'b0);
		host.read(reply);
		check_str(reply, "0,5;1\n");
		run("stat:pres\n", '{32'h6});
		run(":stat:pres\n", '{32'h6});
		run(":STATus:OPER:enab?\n", '{32'h5});
		answer(8'h31);
		run("calc1?\n", '{32'h13});
		answer(8'h37);
		run("cal1?\n", '{32'hffffffff});
		run("calc?\n", '{32'hffffffff});
		run("sens:tc?\n", '{32'hb});
		answer(8'h32);
		run("func\n", '{32'hc});
		run("*ese?;*cls\n", '{32'h03455345, 32'h02434c53});
		answer(8'h30);
		run("init;:init:imm\n", '{32'h10, 32'h10});
		run("stat:pres;*cls;pres\n", '{32'h6, 32'h02434c53, 32'h6});
		run("stat:pres;oper:enab:stat;pres\n", '{32'h6, 32'hffffffff});
		run("stat:opera\n", '{32'hffffffff});
		final_report();
	end
endmodule
